//--- logic/sml_defines.svh
// Constants for the start-up mode pin latch
`ifndef SML_DEFINES_SVH
`define SML_DEFINES_SVH
`define SML_PIN_COUNT       8
`define SML_PULL_ENTRY      29
`define SML_LATCH_RESET     8'h00
`define SML_PULL_ALL_DOWN   8'h00
`define SML_PULL_ALL_UP     8'hff
`endif

//--- logic/sml_pkg.sv
// Types for the start-up mode pin latch
package sml_pkg;
    typedef enum logic [2:0] {
        SML_ST_HOLD  = 3'b001,
        SML_ST_INIT  = 3'b010,
        SML_ST_RUN   = 3'b100
    } sml_state_t;

    typedef struct packed {
        logic [7:0] pull_up;
        logic       others_down;
    } sml_pull_t;
endpackage

//--- logic/sml_startup_latch.sv
// Start-up mode pin capture and pull-direction control
//
// Overview of operation
// RULE1 - Leaving power-on reset, capture eight mode pins
// RULE2 - Warm reset leaves captured configuration unchanged
// RULE3 - Controller holds test reset low during POR; here test_rst_b is only an input, its hold left to the board
// RULE4 - Pull select register picks pull per pin
// RULE5 - Pulldowns applied to mode pins during reset
// RULE6 - After reset, pull select set to pulldown
// RULE7 - Other pulled pins pulled down during reset
// RULE8 - Second POR captures intended mode reliably
// RULE9 - Latch readable, held until next POR
`timescale 1ns/1ps
`include "sml_defines.svh"

module sml_startup_latch
    import sml_pkg::*;
(
    // Clock and resets
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       warm_rst_b,
    input  wire logic       test_rst_b,
    // Mode pins
    input  wire logic [7:0] mode_pins,
    // Pull control
    output sml_pull_t       pull_ctrl,
    // Captured configuration
    output logic [7:0]      startup_config_latch,
    output logic            config_valid
);

    //--------------------------------------------------------------
    // Power-on reset qualification
    //--------------------------------------------------------------
    // Test reset low during power-on reset is the board's duty;
    // it cannot be seen from here, so it is only covered below

    sml_state_t state;
    sml_state_t next_state;
    logic [7:0] pull_direction_select;
    logic       in_warm;

    //--------------------------------------------------------------
    // State decode, shared by the logic and the checks
    //--------------------------------------------------------------
    function automatic logic st_is(input sml_state_t s,
                                   input sml_state_t want);
        return s == want;
    endfunction

    wire       capture_now   = st_is(state, SML_ST_HOLD);  // see RULE1
    wire       load_select   = st_is(state, SML_ST_INIT);  // see RULE6
    wire       in_run        = st_is(state, SML_ST_RUN);
    // Constant today; a select with mixed pulls would load here
    wire [7:0] next_pull_sel = `SML_PULL_ALL_DOWN;         // see RULE6

    always_comb begin
        case (state)
            SML_ST_HOLD: next_state = SML_ST_INIT;
            SML_ST_INIT: next_state = SML_ST_RUN;
            SML_ST_RUN:  next_state = SML_ST_RUN;
            default:     next_state = SML_ST_RUN;
        endcase
    end

    //--------------------------------------------------------------
    // Sequencer, reset only by qualified power-on reset
    //--------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SML_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Pins sampled on the first edge after release; warm reset
    // never touches the latch
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            startup_config_latch <= `SML_LATCH_RESET;
            config_valid         <= 1'b0;
        end else if (capture_now) begin
            startup_config_latch <= mode_pins;            // see RULE1
            config_valid         <= 1'b1;                 // see RULE9
        end
    end

    // Register comes up all-down so the next POR samples cleanly
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_direction_select <= `SML_PULL_ALL_DOWN;  // see RULE8
        end else if (load_select) begin
            pull_direction_select <= next_pull_sel;       // see RULE6
        end
    end

    // Warm reset tracked only for the pull outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_warm <= 1'b1;
        end else begin
            in_warm <= ~warm_rst_b;                       // see RULE2
        end
    end

    //--------------------------------------------------------------
    // Pull outputs: forced down during power-on or warm reset, not test reset
    //--------------------------------------------------------------
    wire in_reset = capture_now | in_warm;
    wire [7:0] next_pull_up = in_reset ? `SML_PULL_ALL_DOWN
                                       : pull_direction_select; // see RULE4

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pull_ctrl.pull_up     <= `SML_PULL_ALL_DOWN;  // see RULE5
            pull_ctrl.others_down <= 1'b1;                // see RULE7
        end else begin
            pull_ctrl.pull_up     <= next_pull_up;        // see RULE5
            pull_ctrl.others_down <= in_reset;            // see RULE7
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_capture_pins: assert property ( // see RULE1
        capture_now |=> startup_config_latch == $past(mode_pins))
        else $error("mode pins not captured at reset release");
    chk_latch_hold: assert property ( // see RULE9
        !capture_now |=> $stable(startup_config_latch))
        else $error("latch changed without power-on reset");
    chk_warm_keeps: assert property ( // see RULE2
        (!warm_rst_b && state == SML_ST_RUN) |=>
            $stable(startup_config_latch))
        else $error("warm reset altered latch");
    chk_pull_init: assert property ( // see RULE6
        state == SML_ST_INIT |=> pull_direction_select == 8'h00)
        else $error("pull select not set to pulldown");
    chk_reset_down: assert property ( // see RULE5
        in_reset |=> pull_ctrl.pull_up == 8'h00)
        else $error("pullup applied during reset");
    chk_others_down: assert property ( // see RULE7
        in_reset |=> pull_ctrl.others_down)
        else $error("other pins not pulled down in reset");
    chk_pull_follow: assert property ( // see RULE4
        !in_reset |=> pull_ctrl.pull_up == $past(pull_direction_select))
        else $error("pull output does not follow select");
    chk_valid_seq: assert property ( // see RULE8
        capture_now |=> config_valid ##1 state == SML_ST_RUN)
        else $error("capture sequence out of order");

    //--------------------------------------------------------------
    // Checks: one capture per power-on reset
    //--------------------------------------------------------------
    chk_valid_hold: assert property ( // see RULE9
        config_valid |=> config_valid)
        else $error("valid flag dropped without power-on reset");
    chk_capture_once: assert property ( // see RULE9
        config_valid |-> !capture_now)
        else $error("second capture after valid");
    chk_state_onehot: assert property ( // see RULE1
        $onehot(state))
        else $error("sequencer state not one-hot");
    chk_hold_exit: assert property ( // see RULE1
        capture_now |=> load_select)
        else $error("capture not followed by select load");
    chk_init_seq: assert property ( // see RULE6
        load_select |=> in_run)
        else $error("select load not followed by run");
    chk_run_stays: assert property ( // see RULE2
        in_run |=> in_run)
        else $error("sequencer left run without power-on reset");
    chk_run_latch: assert property ( // see RULE2
        in_run |=> $stable(startup_config_latch))
        else $error("latch changed while running");
    chk_warm_valid: assert property ( // see RULE2
        (!warm_rst_b && config_valid) |=> $stable(config_valid))
        else $error("warm reset altered valid flag");

    //--------------------------------------------------------------
    // Checks: pulls around warm reset
    //--------------------------------------------------------------
    // Warm reset reaches the pulls a cycle late through in_warm;
    // the latch and the valid flag never see it
    // Two edges: one into in_warm, one into the pull register
    chk_warm_down: assert property ( // see RULE7
        !warm_rst_b |-> ##2 pull_ctrl.others_down)
        else $error("warm reset did not pull other pins down");
    chk_run_release: assert property ( // see RULE7
        (in_run && !in_warm) |=> !pull_ctrl.others_down)
        else $error("other pins still pulled down after reset");
    chk_sel_steady: assert property ( // see RULE6
        in_run |=> $stable(pull_direction_select))
        else $error("pull select changed while running");

    //--------------------------------------------------------------
    // Per-pin pairing
    //--------------------------------------------------------------
    // One pairing and one pull assertion per pin, so a swapped pair names its bit
    for (genvar g = 0; g < `SML_PIN_COUNT; g++) begin : g_pin
        chk_pin_pair: assert property ( // see RULE1
            capture_now |=> startup_config_latch[g] == $past(mode_pins[g]))
            else $error("mode pin not paired with its latch bit");
        chk_pin_pull: assert property ( // see RULE4
            !in_reset |=> pull_ctrl.pull_up[g] ==
                $past(pull_direction_select[g]))
            else $error("pin pull does not follow its select bit");
    end

    //--------------------------------------------------------------
    // Coverage
    //--------------------------------------------------------------
    cov_capture:  cover property (capture_now ##1 config_valid);
    cov_warm:     cover property (state == SML_ST_RUN ##1 !warm_rst_b);
    cov_run:      cover property (state == SML_ST_RUN && !in_reset);
    // The test reset release is only watched, never acted on
    cov_trst_rel: cover property ($rose(test_rst_b) ##1 config_valid);

endmodule

//--- test/sml_startup_latch_test.sv
// Self-checking bench for the start-up mode pin latch
`timescale 1ns/1ps
module sml_startup_latch_test
    import sml_pkg::*;
;
    logic        ref_clk, rst_b, warm_rst_b, test_rst_b, config_valid;
    logic [7:0]  strap, fitted, mode_pins, startup_config_latch, held;
    sml_pull_t   pull_ctrl;
    int          n_errors = 0, n_compared = 0, k;
    logic [31:0] seed = 32'h00015aa1;

    sml_strap_model straps (.strap(strap), .fitted(fitted),
        .pull_ctrl(pull_ctrl), .mode_pins(mode_pins));
    sml_startup_latch uut (.ref_clk(ref_clk), .rst_b(rst_b),
        .warm_rst_b(warm_rst_b), .test_rst_b(test_rst_b),
        .mode_pins(mode_pins), .pull_ctrl(pull_ctrl),
        .startup_config_latch(startup_config_latch),
        .config_valid(config_valid));

    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Pulldowns in reset make unfitted pins read low
    function automatic logic [7:0] exp_pins(input logic [7:0] s, f);
        return s & f;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_pulls(input logic [7:0] others);
        check("pull_up", pull_ctrl.pull_up, 8'h00);
        check("others_down", 8'(pull_ctrl.others_down), others);
    endtask

    task automatic por(input int cyc);
        rst_b <= 0;
        test_rst_b <= 0;
        repeat (cyc) @(posedge ref_clk);
        check_pulls(8'h01);
        #1 rst_b = 1;
        test_rst_b = 1;
        for (k = 0; k < 4 && config_valid !== 1'b1; k++) begin
            @(posedge ref_clk);
            #2;
        end
        // A hang counts here; the run still ends at the one verdict
        if (config_valid !== 1'b1) begin
            n_errors++;
        end
        check("capture_edge", 8'(k), 8'h01);
        held = exp_pins(strap, fitted);
        check("latch", startup_config_latch, held);
        repeat (3) @(posedge ref_clk);
        #1 check_pulls(8'h00);
    endtask

    initial begin
        rst_b = 0;
        test_rst_b = 0;
        warm_rst_b = 1;
        strap = 8'h00;
        fitted = 8'hff;
        por(20);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            strap = (i == 1) ? 8'hff : seed[7:0];
            fitted = (i == 7) ? 8'h00 : (i[0] ? seed[15:8] : 8'hff);
            por(2 + i);
            held = startup_config_latch;
            strap = ~strap;
            fitted = 8'hff;
            warm_rst_b = 0;
            repeat (3) @(posedge ref_clk);
            #1 check_pulls(8'h01);
            check("warm_latch", startup_config_latch, held);
            warm_rst_b = 1;
            repeat (4) @(posedge ref_clk);
            #1 check("held_latch", startup_config_latch, held);
            $display("test %0d done", i);
        end
        give_verdict();
    end
endmodule

//--- test/sml_strap_model.sv
// Strap resistor model for the start-up mode pins
`timescale 1ns/1ps
module sml_strap_model
    import sml_pkg::*;
(
    // Strap setting, fitted marks pins with a resistor
    input  wire logic [7:0] strap,
    input  wire logic [7:0] fitted,
    // Device pulls
    input  wire sml_pull_t  pull_ctrl,
    // Pins
    output logic [7:0]      mode_pins
);
    // Unfitted pins float to whatever the device pulls them to
    assign mode_pins = (strap & fitted) | (pull_ctrl.pull_up & ~fitted);
endmodule
